//--- hdl/tsi_pkg.sv
// package: constants shared by both ends of the two-wire sensor port
package tsi_pkg;
  localparam logic [3:0] TSI_ADDR_FIXED  = 4'h9;    // fixed upper address nibble 1001
  localparam logic [1:0] TSI_PTR_TEMP    = 2'h0;
  localparam logic [1:0] TSI_PTR_CONFIG  = 2'h1;
  localparam logic [1:0] TSI_PTR_HYST    = 2'h2;
  localparam logic [1:0] TSI_PTR_LIMIT   = 2'h3;
  localparam logic       TSI_DIR_READ    = 1'b1;
  localparam logic       TSI_DIR_WRITE   = 1'b0;
  localparam int         TSI_BYTE_BITS   = 8;
  localparam logic [7:0] TSI_CONFIG_RST  = 8'h00;
  localparam logic [15:0] TSI_LIMIT_RST  = 16'h5000;  // 80 degrees
  localparam logic [15:0] TSI_HYST_RST   = 16'h4B00;  // 75 degrees
  localparam int         TSI_RES_POS     = 5;         // config resolution field, bits 6:5
  localparam int         TSI_CONV_MIN_MS = 30;        // coarsest step conversion
  localparam int         TSI_CONV_MAX_MS = 240;       // finest step conversion
  // bus timing for the master end, in ns
  localparam int         TSI_CLK_NS      = 5;
  localparam int         TSI_TLOW_NS     = 1300;
  localparam int         TSI_THIGH_NS    = 600;
  localparam int         TSI_TSU_NS      = 100;       // data setup before clock rise
  localparam int         TSI_FREE_NS     = 1300;      // bus_free_interval
  localparam int         TSI_TLOW_CYC    = (TSI_TLOW_NS + TSI_CLK_NS - 1) / TSI_CLK_NS;
  localparam int         TSI_THIGH_CYC   = (TSI_THIGH_NS + TSI_CLK_NS - 1) / TSI_CLK_NS;
  localparam int         TSI_TSU_CYC     = (TSI_TSU_NS + TSI_CLK_NS - 1) / TSI_CLK_NS;
  localparam int         TSI_FREE_CYC    = (TSI_FREE_NS + TSI_CLK_NS - 1) / TSI_CLK_NS;
endpackage

//--- hdl/tsi_bus_if.sv
// interface: the shared two-wire bus with open-drain resolution
`timescale 1ns/10ps
interface tsi_bus_if;
  logic scl_oe_n;   // master pulls clock low when 0
  logic msda_oe_n;  // master pulls data low when 0
  logic ssda_oe_n;  // slave pulls data low when 0
  logic scl;
  logic sda;
  // wired-and with pull-ups
  assign scl = scl_oe_n;
  assign sda = msda_oe_n & ssda_oe_n;
  modport slave  (input scl, input sda, output ssda_oe_n);
  modport master (input scl, input sda, output scl_oe_n, output msda_oe_n);
endinterface

//--- hdl/tsi_slave.sv
// module: sensor end of the two-wire port with register file
//
// Summary of operation
// - SDA falling while SCL high is Start
// - SDA rising while SCL high is Stop
// - Start mid-transfer restarts the protocol state
// - Stop while transmitting releases SDA at once
// - address is 1001 plus three select pins
// - ACK only own address, else idle
// - eighth address bit: 1 read, 0 write
// - receiver acknowledges each byte in slot nine
// - master gives ninth clock for acknowledge
// - ACK held low across acknowledge clock pulse
// - master NAK ends read, slave releases SDA
// - no auto-increment across registers
// - pointer kept for later reads
// - each repeated read starts with Start, address
// - master ends every access with Stop
// - master waits bus-free time after Stop
// - data changes only while SCL low
// - bus idle when SDA and SCL high; o_bus_busy here clears only on Stop
// - only master makes Start and Stop
// - resolution selectable, trading time for precision
// - first written byte is two-bit pointer
`timescale 1ns/10ps
module tsi_slave
  import tsi_pkg::*;
(
  input  wire logic        i_clk_sys,       // system clock
  input  wire logic        i_rst,           // async reset, high
  tsi_bus_if.slave         bus,             // two-wire bus
  input  wire logic        i_addr_sel_bit2, // address strap
  input  wire logic        i_addr_sel_bit1, // address strap
  input  wire logic        i_addr_sel_bit0, // address strap
  input  wire logic [15:0] i_temp,          // converter result
  output logic       [7:0] o_config,        // configuration register
  output logic      [15:0] o_hyst,          // hysteresis register
  output logic      [15:0] o_limit,         // limit register
  output logic       [1:0] o_resolution,    // resolution select to converter
  output logic             o_bus_busy       // level: bus not idle
);
  import tsi_pkg::*;

  typedef enum {TSI_IDLE, TSI_ADDR, TSI_RX, TSI_TX} tsi_state_t;

  // ****************************************************
  // line sampling and condition detect
  // ****************************************************
  logic scl_q, sda_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end
  wire start_det = scl_q & bus.scl & sda_q & ~bus.sda;
  wire stop_det  = scl_q & bus.scl & ~sda_q & bus.sda;
  wire scl_rise  = ~scl_q & bus.scl;   // data sampled here
  wire scl_fall  = scl_q & ~bus.scl;   // data changes here
  wire [6:0] own_addr = {TSI_ADDR_FIXED, i_addr_sel_bit2,
                         i_addr_sel_bit1, i_addr_sel_bit0};

  // ****************************************************
  // protocol engine
  // ****************************************************
  tsi_state_t state;
  logic [3:0] bit_cnt;     // 0..7 data bits, 8 = acknowledge slot
  logic [7:0] shreg;
  logic       ack_drv;     // pulling SDA low for acknowledge
  logic       tx_drv;      // pulling SDA low for a data 0
  logic       byte_idx;    // which byte of a word
  logic       ptr_phase;   // next written byte is pointer
  logic [1:0] ptr;
  logic       nak_seen;
  logic       ack_phase;   // inside the acknowledge clock pulse
  logic [7:0] wr_hi;

  wire        is_cfg   = (ptr == TSI_PTR_CONFIG);
  wire [15:0] rd_word  = (ptr == TSI_PTR_TEMP)   ? i_temp :
                         (ptr == TSI_PTR_CONFIG) ? {o_config, 8'h00} :
                         (ptr == TSI_PTR_HYST)   ? o_hyst : o_limit;
  // upper byte first, config single byte
  wire [7:0]  rd_byte  = byte_idx ? rd_word[7:0] : rd_word[15:8];
  wire        last_rd  = is_cfg | byte_idx;   // no advance past a register
  wire        ack_slot = (bit_cnt == 4'd8);

  assign bus.ssda_oe_n = ~(ack_drv | tx_drv);
  assign o_resolution  = o_config[TSI_RES_POS +: 2];

  // busy from Start to Stop; only a Stop clears it, both lines high alone does not
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_bus_busy <= 1'b0;
    end else if (start_det) begin
      o_bus_busy <= 1'b1;
    end else if (stop_det) begin
      o_bus_busy <= 1'b0;
    end
  end

  // main sequencer, stepped by SCL edges
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state     <= TSI_IDLE;
      bit_cnt   <= 4'd0;
      shreg     <= 8'h00;
      ack_drv   <= 1'b0;
      tx_drv    <= 1'b0;
      byte_idx  <= 1'b0;
      ptr_phase <= 1'b0;
      ptr       <= TSI_PTR_TEMP;
      nak_seen  <= 1'b0;
      ack_phase <= 1'b0;
      wr_hi     <= 8'h00;
      o_config  <= TSI_CONFIG_RST;
      o_hyst    <= TSI_HYST_RST;
      o_limit   <= TSI_LIMIT_RST;
    end else if (start_det) begin
      state    <= TSI_ADDR;   // abandon anything in progress
      bit_cnt  <= 4'd0;
      ack_drv  <= 1'b0;
      tx_drv   <= 1'b0;
      byte_idx <= 1'b0;
      nak_seen <= 1'b0;
      ack_phase <= 1'b0;
    end else if (stop_det) begin
      state   <= TSI_IDLE;
      ack_drv <= 1'b0;
      tx_drv  <= 1'b0;
    end else if (scl_rise && state != TSI_IDLE) begin
      if (!ack_slot) begin
        // while sending, shreg holds outgoing bits and must not take the line back
        if (state != TSI_TX) shreg <= {shreg[6:0], bus.sda};   // MSB first
      end else if (state == TSI_TX) begin
        nak_seen <= bus.sda;              // master ack or end_of_read_marker
      end
      ack_phase <= ack_slot;
      bit_cnt <= ack_slot ? 4'd0 : bit_cnt + 4'd1;   // ninth pulse from master
    end else if (scl_fall && state != TSI_IDLE) begin
      ack_drv <= 1'b0;   // ack released after falling edge
      tx_drv  <= 1'b0;
      ack_phase <= 1'b0;
      if (bit_cnt == 4'd8) begin
        // eight bits in: decide on the acknowledge slot
        case (state)
          TSI_ADDR: begin
            if (shreg[7:1] == own_addr) begin
              ack_drv   <= 1'b1;
              ptr_phase <= (shreg[0] == TSI_DIR_WRITE);
              byte_idx  <= 1'b0;
            end else begin
              state <= TSI_IDLE;                 // silent until next Start
            end
          end
          TSI_RX: begin
            ack_drv <= 1'b1;
            if (ptr_phase) begin
              ptr       <= shreg[1:0];           // pointer_sel_hi/lo held
              ptr_phase <= 1'b0;
              byte_idx  <= 1'b0;
            end else if (ptr == TSI_PTR_TEMP) begin
              byte_idx <= ~byte_idx;             // read-only target ignored
            end else if (is_cfg) begin
              o_config <= shreg;
            end else if (!byte_idx) begin
              wr_hi    <= shreg;
              byte_idx <= 1'b1;
            end else begin
              if (ptr == TSI_PTR_HYST) o_hyst <= {wr_hi, shreg};
              else                     o_limit <= {wr_hi, shreg};
              byte_idx <= 1'b0;                  // stays on this register
            end
          end
          TSI_TX: ;
          default: state <= TSI_IDLE;
        endcase
      end else if (ack_phase) begin
        // acknowledge slot finished: choose next phase; the first fall after
        // a Start also has bit_cnt 0, hence the flag rather than the count
        case (state)
          TSI_ADDR: begin
            state <= (shreg[0] == TSI_DIR_READ) ? TSI_TX : TSI_RX;
            if (shreg[0] == TSI_DIR_READ) begin
              tx_drv <= ~rd_byte[7];
              shreg  <= {rd_byte[6:0], 1'b1};
            end
          end
          TSI_TX: begin
            if (nak_seen || last_rd) begin
              state <= TSI_IDLE;                 // keep SDA released
            end else begin
              byte_idx <= 1'b1;
              tx_drv   <= ~rd_word[7];
              shreg    <= {rd_word[6:0], 1'b1};
            end
          end
          TSI_RX: ;
          default: state <= TSI_IDLE;
        endcase
      end else if (state == TSI_TX) begin
        tx_drv <= ~shreg[7];                     // change only with SCL low
        shreg  <= {shreg[6:0], 1'b1};
      end
    end
  end

  // converter time doubles per resolution step, 30 ms to 240 ms; the
  // converter sits outside this port and only reads o_resolution
  initial assert (TSI_CONV_MIN_MS * 8 == TSI_CONV_MAX_MS);
endmodule // tsi_slave

//--- hdl/tsi_master.sv
// module: bus-master end issuing register reads and writes
`timescale 1ns/10ps
module tsi_master
  import tsi_pkg::*;
#(
  parameter int DEPTH = 2   // request buffer entries
)(
  input  wire logic        i_clk_sys,     // system clock
  input  wire logic        i_rst,         // async reset, high
  tsi_bus_if.master        bus,           // two-wire bus
  input  wire logic        i_req_valid,   // request offered
  output logic             o_req_ready,   // request accepted
  input  wire logic        i_req_read,    // 1 read, 0 write
  input  wire logic  [6:0] i_req_addr,    // slave address
  input  wire logic  [1:0] i_req_ptr,     // register pointer
  input  wire logic  [1:0] i_req_nbytes,  // data bytes, 0..2
  input  wire logic [15:0] i_req_data,    // write data, upper byte first
  output logic             o_rsp_valid,   // result ready
  input  wire logic        i_rsp_ready,   // result taken
  output logic      [15:0] o_rsp_data,    // read data
  output logic             o_rsp_nak      // slave did not acknowledge
);
  import tsi_pkg::*;
  typedef enum {TM_IDLE, TM_START, TM_BIT, TM_STOP, TM_FREE} tm_state_t;
  initial assert (DEPTH == 2);

  // ****************************************************
  // two-entry request buffer
  // ****************************************************
  localparam int W = 1 + 7 + 2 + 2 + 16;
  logic [W-1:0] mem [DEPTH];
  logic         wp, rp;
  logic [1:0]   cnt;
  logic         pop;
  wire  [W-1:0] head = mem[rp];
  assign o_req_ready = (cnt != 2'(DEPTH));
  // storage kept out of the reset so it maps to plain registers
  always_ff @(posedge i_clk_sys) begin
    if (i_req_valid && o_req_ready) begin
      mem[wp] <= {i_req_read, i_req_addr, i_req_ptr, i_req_nbytes, i_req_data};
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wp <= 1'b0; rp <= 1'b0; cnt <= 2'd0;
    end else begin
      if (i_req_valid && o_req_ready) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= cnt + 2'(i_req_valid && o_req_ready) - 2'(pop);
    end
  end

  // ****************************************************
  // bit sequencer: byte list of up to four, ninth slot each
  // ****************************************************
  tm_state_t  st;
  logic [11:0] tmr;
  logic [1:0]  phase;       // 0 low, 2 data setup, 1 high
  logic [3:0]  bitn;
  logic [2:0]  bytn, nbyt;
  logic [7:0]  cur;
  logic        scl_n, sda_n, rd;
  wire  [7:0]  b0 = {head[26:20], head[27]};   // address, then direction bit
  wire  [7:0]  b1 = {6'h00, head[19:18]};      // pointer, upper six bits zero
  // byte after the current one, picked while bytn still names the old byte
  wire  [2:0]  bytn_nx = bytn + 3'd1;
  wire  [7:0]  bsel = (bytn_nx == 3'd1 && !rd) ? b1 :
                      (bytn_nx == 3'd2 - 3'(rd)) ? head[15:8] : head[7:0];
  wire         rx = rd && bytn != 3'd0;
  assign bus.scl_oe_n  = scl_n;
  assign bus.msda_oe_n = sda_n;
  // the response waits in its own register, so the entry goes when the bus-free wait ends
  assign pop = (st == TM_FREE) && tmr == 12'd0;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st <= TM_IDLE; tmr <= 12'd0; phase <= 2'd0; bitn <= 4'd0;
      bytn <= 3'd0; nbyt <= 3'd0; cur <= 8'h00; scl_n <= 1'b1;
      sda_n <= 1'b1; rd <= 1'b0; o_rsp_valid <= 1'b0;
      o_rsp_data <= 16'h0000; o_rsp_nak <= 1'b0;
    end else begin
      if (o_rsp_valid && i_rsp_ready) o_rsp_valid <= 1'b0;
      if (tmr != 12'd0) tmr <= tmr - 12'd1;
      else case (st)
        TM_IDLE: if (cnt != 2'd0 && !o_rsp_valid) begin
          // every access opens with its own Start from this end
          rd <= head[27]; o_rsp_nak <= 1'b0; o_rsp_data <= 16'h0000;
          nbyt <= 3'(head[17:16]) + (head[27] ? 3'd1 : 3'd2);
          sda_n <= 1'b0; tmr <= 12'(TSI_THIGH_CYC); st <= TM_START;
        end
        TM_START: begin
          scl_n <= 1'b0; bytn <= 3'd0; bitn <= 4'd0; phase <= 2'd0;
          cur <= b0; tmr <= 12'(TSI_TLOW_CYC); st <= TM_BIT;
        end
        TM_BIT: if (phase == 2'd0) begin
          // low half: settle SDA a setup time before the clock rises
          if (bitn < 4'd8) sda_n <= rx ? 1'b1 : cur[7];
          else sda_n <= rx ? (bytn == nbyt - 3'd1) : 1'b1;  // ack or final NAK
          phase <= 2'd2; tmr <= 12'(TSI_TSU_CYC);
        end else if (phase == 2'd2) begin
          scl_n <= 1'b1; phase <= 2'd1; tmr <= 12'(TSI_THIGH_CYC);
        end else begin
          scl_n <= 1'b0; phase <= 2'd0; tmr <= 12'(TSI_TLOW_CYC);
          if (bitn < 4'd8) begin
            cur <= {cur[6:0], 1'b0};
            if (rx) o_rsp_data <= {o_rsp_data[14:0], bus.sda};
            bitn <= bitn + 4'd1;
          end else begin
            bitn <= 4'd0;
            if (!rx && bus.sda) begin o_rsp_nak <= 1'b1; st <= TM_STOP; end
            else if (bytn == nbyt - 3'd1) st <= TM_STOP;
            else begin bytn <= bytn + 3'd1; end
          end
          if (bitn == 4'd8) sda_n <= 1'b0;
        end
        TM_STOP: begin   // clock up, then data up
          if (!scl_n) begin scl_n <= 1'b1; sda_n <= 1'b0; tmr <= 12'(TSI_THIGH_CYC); end
          else begin sda_n <= 1'b1; tmr <= 12'(TSI_FREE_CYC); st <= TM_FREE; o_rsp_valid <= 1'b1; end
        end
        TM_FREE: st <= TM_IDLE;   // bus_free_interval has run out
        default: st <= TM_IDLE;
      endcase
      if (st == TM_BIT && phase == 2'd1 && bitn == 4'd8 && tmr == 12'd0) cur <= bsel;
    end
  end
endmodule // tsi_master

//--- verif/tsi_bus_assertions.sv
// checker: wire-level rules on the shared two-wire bus
`timescale 1ns/10ps
module tsi_bus_assertions
  import tsi_pkg::*;
(
  input  wire logic i_clk_sys,  // system clock
  input  wire logic i_rst,      // async reset, high
  input  wire logic scl_oe_n,   // master clock drive
  input  wire logic msda_oe_n,  // master data drive
  input  wire logic ssda_oe_n,  // slave data drive
  input  wire logic scl,        // resolved clock
  input  wire logic sda         // resolved data
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ****************************************
  // bus event tracking
  // ****************************************
  logic        p_scl;
  logic        p_sda;
  logic        busy;
  logic [15:0] hi_cnt;
  logic [15:0] free_cnt;
  logic [3:0]  bit_cnt;
  wire         start = p_scl & scl & p_sda & ~sda;
  wire         stop  = p_scl & scl & ~p_sda & sda;
  wire         rise  = ~p_scl & scl;
  // previous levels and busy span; reset to idle bus
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      p_scl <= 1'h1;
      p_sda <= 1'h1;
      busy  <= 1'h0;
    end else begin
      p_scl <= scl;
      p_sda <= sda;
      busy  <= start | (busy & ~stop);
    end
  end
  // hi_cnt and free_cnt saturate so a long idle never wraps into a short count
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hi_cnt   <= 16'h0000;
      free_cnt <= 16'hFFFF;
      bit_cnt  <= 4'h0;
    end else begin
      hi_cnt   <= scl ? hi_cnt + {15'h0000, ~&hi_cnt} : 16'h0000;
      free_cnt <= stop ? 16'h0000 : free_cnt + {15'h0000, ~&free_cnt};
      bit_cnt  <= start ? 4'h0 : (rise ? ((bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1) : bit_cnt);
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  sequence s_released;
    ssda_oe_n [*4];
  endsequence
  slave_data_timing_a: assert property ($changed(ssda_oe_n) |-> !scl)
    else $error("slave data moved while clock high");
  idle_quiet_a: assert property (!busy |-> ssda_oe_n)
    else $error("slave drove data on idle bus");
  stop_release_a: assert property (stop |-> s_released)
    else $error("slave held data after stop");
  start_reset_a: assert property (start |-> s_released)
    else $error("slave drove data right after start");
  ack_hold_a: assert property ($rose(scl) && !ssda_oe_n |-> !ssda_oe_n [*8])
    else $error("acknowledge not held through clock high");
  // the Stop's own clock rise counts as one after the last acknowledge
  ninth_clock_a: assert property (stop |-> bit_cnt == 4'h1)
    else $error("frame not a whole number of nine-clock bytes");
  // one cycle of slack for how the master end counts its wait
  bus_free_a: assert property (start |-> free_cnt >= TSI_FREE_CYC - 1)
    else $error("start too soon after stop");
  clock_high_a: assert property ($fell(scl) |-> hi_cnt >= TSI_THIGH_CYC - 1)
    else $error("clock high time too short");
  master_data_a: assert property ($changed(msda_oe_n) && scl_oe_n |-> start || stop)
    else $error("master data moved while clock high outside start or stop");
endmodule // tsi_bus_assertions

//--- verif/tb_temp_sensor_i2c_slave_port.sv
// testbench: master and sensor ends joined, register traffic checked
`timescale 1ns/10ps
module tb_temp_sensor_i2c_slave_port;
  import tsi_pkg::*;
  logic        i_clk_sys, i_rst, req_valid, req_ready, req_read, rsp_valid, rsp_ready;
  logic        rsp_nak, bus_busy;
  logic [2:0]  sel;
  logic [1:0]  req_ptr, req_nbytes, res;
  logic [6:0]  req_addr;
  logic [7:0]  cfg, cw;
  logic [15:0] temp, hyst, limit, req_data, rsp_data, lim, d2;
  logic [31:0] seed, r;
  int          n_fail, tests_run, cyc;
  tsi_bus_if tsi_bus_if_i ();
  tsi_slave tsi_slave_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(tsi_bus_if_i),
    .i_addr_sel_bit2(sel[2]), .i_addr_sel_bit1(sel[1]), .i_addr_sel_bit0(sel[0]),
    .i_temp(temp), .o_config(cfg), .o_hyst(hyst), .o_limit(limit),
    .o_resolution(res), .o_bus_busy(bus_busy));
  tsi_master tsi_master_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(tsi_bus_if_i),
    .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_read(req_read),
    .i_req_addr(req_addr), .i_req_ptr(req_ptr), .i_req_nbytes(req_nbytes),
    .i_req_data(req_data), .o_rsp_valid(rsp_valid), .i_rsp_ready(rsp_ready),
    .o_rsp_data(rsp_data), .o_rsp_nak(rsp_nak));
  tsi_bus_assertions tsi_bus_assertions_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .scl_oe_n(tsi_bus_if_i.scl_oe_n), .msda_oe_n(tsi_bus_if_i.msda_oe_n),
    .ssda_oe_n(tsi_bus_if_i.ssda_oe_n), .scl(tsi_bus_if_i.scl), .sda(tsi_bus_if_i.sda));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [6:0] own();
    return {TSI_ADDR_FIXED, sel};
  endfunction
  function automatic logic [1:0] f_res(input logic [7:0] c);
    return c[TSI_RES_POS +: 2];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // request held from a falling edge until a rising edge finds ready
  task automatic push(input logic rd, input logic [6:0] a, input logic [1:0] p,
                      input logic [1:0] n, input logic [15:0] d);
    @(negedge i_clk_sys);
    req_valid = 1'h1;
    req_read = rd;
    req_addr = a;
    req_ptr = p;
    req_nbytes = n;
    req_data = d;
    while (req_ready !== 1'h1) @(negedge i_clk_sys);
    @(negedge i_clk_sys);
    req_valid = 1'h0;
  endtask
  // receiver stalls a random while; m[0] checks nak, m[1] read data
  task automatic collect(input logic [1:0] m, input logic nak, input logic [15:0] d);
    while (rsp_valid !== 1'h1) @(negedge i_clk_sys);
    repeat (rnd() % 8) @(negedge i_clk_sys);
    if (m[0]) chk({15'h0000, rsp_nak}, {15'h0000, nak});
    if (m[1]) chk(rsp_data, d);
    rsp_ready = 1'h1;
    @(negedge i_clk_sys);
    rsp_ready = 1'h0;
  endtask
  // ****************************************
  // clock, watchdog, scenarios
  // ****************************************
  initial begin
    i_clk_sys = 1'h0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  // about 90k cycles expected; a hang counts as a mismatch
  initial begin
    cyc = 0;
    forever begin
      @(posedge i_clk_sys);
      cyc++;
      if (cyc == 100000) begin
        n_fail++;
        report_and_stop();
      end
    end
  end
  initial begin
    seed = 32'h020B;
    n_fail = 0;
    tests_run = 0;
    i_rst = 1'h1;
    req_valid = 1'h0;
    rsp_ready = 1'h0;
    {req_read, req_addr, req_ptr, req_nbytes, req_data} = '0;
    r = rnd();
    sel = r[2:0];
    temp = r[31:16];
    r = rnd();
    lim = r[15:0];
    cw = r[23:16];
    r = rnd();
    d2 = r[15:0];
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'h0;
    chk(hyst, TSI_HYST_RST);
    push(1'h0, own(), TSI_PTR_LIMIT, 2'h2, lim);
    push(1'h0, own(), TSI_PTR_CONFIG, 2'h1, {cw, cw});
    push(1'h1, own(), TSI_PTR_TEMP, 2'h1, 16'h0000);
    chk({15'h0000, req_ready}, 16'h0000); // buffer full: second and third requests both waiting
    collect(2'h1, 1'h0, 16'h0000);
    collect(2'h1, 1'h0, 16'h0000);
    collect(2'h3, 1'h0, {8'h00, cw});
    chk(limit, lim);
    chk({8'h00, cfg}, {8'h00, cw});
    chk({14'h0000, res}, {14'h0000, f_res(cw)});
    push(1'h0, own(), TSI_PTR_TEMP, 2'h2, d2);
    push(1'h1, own(), TSI_PTR_HYST, 2'h2, 16'h0000);
    collect(2'h1, 1'h0, 16'h0000);
    collect(2'h3, 1'h0, temp);
    chk(limit, lim);
    push(1'h0, own() ^ 7'h01, TSI_PTR_HYST, 2'h2, lim);
    collect(2'h1, 1'h1, 16'h0000);
    chk(hyst, TSI_HYST_RST);
    push(1'h0, own(), TSI_PTR_HYST, 2'h0, 16'h0000);
    push(1'h1, own(), TSI_PTR_TEMP, 2'h2, 16'h0000);
    collect(2'h1, 1'h0, 16'h0000);
    collect(2'h3, 1'h0, TSI_HYST_RST);
    chk({15'h0000, bus_busy}, 16'h0000);
    report_and_stop();
  end
endmodule // tb_temp_sensor_i2c_slave_port
